// [inc/uafc_pkg.sv]
package uafc_pkg;

  // Register indexes; the byte address is four times the index
  localparam logic [9:0] IDX_OWN0  = 10'h0a9;
  localparam logic [9:0] IDX_OWN1  = 10'h0aa;
  localparam logic [9:0] IDX_MASK0 = 10'h0b9;
  localparam logic [9:0] IDX_MASK1 = 10'h0ba;
  localparam logic [9:0] IDX_CTRL0 = 10'h0c0;
  localparam logic [9:0] IDX_CTRL1 = 10'h0c1;
  localparam logic [9:0] IDX_T2CTL = 10'h0c2;
  localparam logic [9:0] IDX_STAT  = 10'h0c3;
  localparam logic [9:0] IDX_IEN   = 10'h0c4;

  // Values after reset
  localparam logic [7:0] OWN_RST   = 8'h00;
  localparam logic [7:0] MASK_RST  = 8'h00;
  localparam logic [4:0] CTRL_RST  = 5'h00;
  localparam logic [1:0] T2_RST    = 2'h0;
  localparam logic [3:0] STAT_RST  = 4'h0;
  localparam logic [3:0] IEN_RST   = 4'h0;

  // Field positions of the port control register
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_MPE      = 2;
  localparam int CTRL_RXGEN    = 3;
  localparam int CTRL_TXGEN    = 4;
  // Field positions of the timer-2 control register
  localparam int T2_RXSEL = 0;
  localparam int T2_TXSEL = 1;

  // Bus transfer size for a whole word
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {
    MODE_SHIFT  = 2'h0,
    MODE_UART8  = 2'h1,
    MODE_UART9F = 2'h2,
    MODE_UART9V = 2'h3
  } uafc_mode_t;

  typedef enum logic [1:0] {
    SRC_TIMER1 = 2'h0,
    SRC_TIMER2 = 2'h1,
    SRC_BRG    = 2'h2,
    SRC_FIXED  = 2'h3
  } uafc_src_t;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_RDWAIT = 2'b10
  } uafc_bus_t;

  // Equality of two bytes on the bits where care is one
  function automatic logic masked_equal(input logic [7:0] rx, input logic [7:0] pattern, input logic [7:0] care);
    return ((rx ^ pattern) & care) == 8'h00;
  endfunction : masked_equal

endpackage : uafc_pkg

// [inc/uafc_port_if.sv]
`timescale 1ns/1ps
interface uafc_port_if;
  uafc_pkg::uafc_mode_t mode;
  logic                 mpEnable;
  logic                 txGenSel;
  logic                 rxGenSel;
  logic                 txT2Sel;
  logic                 rxT2Sel;
  logic [7:0]           ownAddr;
  logic [7:0]           addrMask;
  logic                 frameDone;
  logic [7:0]           frameData;
  logic                 frameNinth;
  logic                 stopValid;
  logic                 t1Tick;
  logic                 t2Tick;
  logic                 brgTick;
  logic                 accept;
  logic                 reject;
  logic                 txTick;
  logic                 rxTick;
  uafc_pkg::uafc_src_t  txSrc;
  uafc_pkg::uafc_src_t  rxSrc;

  modport ctl (output mode, mpEnable, txGenSel, rxGenSel, txT2Sel, rxT2Sel, ownAddr, addrMask,
               frameDone, frameData, frameNinth, stopValid, t1Tick, t2Tick, brgTick,
               input accept, reject, txTick, rxTick, txSrc, rxSrc);
  modport flt (input mode, mpEnable, txGenSel, rxGenSel, txT2Sel, rxT2Sel, ownAddr, addrMask,
               frameDone, frameData, frameNinth, stopValid, t1Tick, t2Tick, brgTick,
               output accept, reject, txTick, rxTick, txSrc, rxSrc);
endinterface : uafc_port_if

// [rtl/uafc_port_filter.sv]
`timescale 1ns/1ps
module uafc_port_filter (
  input wire logic clk,
  input wire logic sys_rst,
  uafc_port_if.flt p
);

  // Source choice for one direction
  function automatic uafc_pkg::uafc_src_t pick_src(input logic varRate, input logic genSel, input logic t2Sel);
    if (!varRate) begin
      return uafc_pkg::SRC_FIXED;
    end
    if (genSel) begin
      return uafc_pkg::SRC_BRG;
    end
    return t2Sel ? uafc_pkg::SRC_TIMER2 : uafc_pkg::SRC_TIMER1;
  endfunction : pick_src

  // Tick of the chosen source
  function automatic logic pick_tick(input uafc_pkg::uafc_src_t src, input logic t1, input logic t2, input logic brg);
    case (src)
      uafc_pkg::SRC_TIMER1: pick_tick = t1;
      uafc_pkg::SRC_TIMER2: pick_tick = t2;
      uafc_pkg::SRC_BRG:    pick_tick = brg;
      default:              pick_tick = 1'b0;
    endcase
  endfunction : pick_tick

  // Address recognition decode
  wire        recogOn   = p.mpEnable && (p.mode != uafc_pkg::MODE_SHIFT);
  wire [7:0]  bcastAddr = p.ownAddr | p.addrMask;
  wire        givenHit  = uafc_pkg::masked_equal(p.frameData, p.ownAddr, p.addrMask);
  wire        bcastHit  = uafc_pkg::masked_equal(p.frameData, bcastAddr, bcastAddr);
  wire        frameMark = (p.mode == uafc_pkg::MODE_UART8) ? p.stopValid : p.frameNinth;
  wire        passFrame = !recogOn || (frameMark && (givenHit || bcastHit));
  wire        varRate   = (p.mode == uafc_pkg::MODE_UART8) || (p.mode == uafc_pkg::MODE_UART9V);
  uafc_pkg::uafc_src_t txSrc_next;
  uafc_pkg::uafc_src_t rxSrc_next;
  assign txSrc_next = pick_src(varRate, p.txGenSel, p.txT2Sel);
  assign rxSrc_next = pick_src(varRate, p.rxGenSel, p.rxT2Sel);

  // Frame verdict and clock routing flops
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      p.accept <= 1'b0;
      p.reject <= 1'b0;
      p.txSrc  <= uafc_pkg::SRC_TIMER1;
      p.rxSrc  <= uafc_pkg::SRC_TIMER1;
      p.txTick <= 1'b0;
      p.rxTick <= 1'b0;
    end else begin
      p.accept <= p.frameDone && passFrame;
      p.reject <= p.frameDone && !passFrame;
      p.txSrc  <= txSrc_next;
      p.rxSrc  <= rxSrc_next;
      p.txTick <= pick_tick(txSrc_next, p.t1Tick, p.t2Tick, p.brgTick);
      p.rxTick <= pick_tick(rxSrc_next, p.t1Tick, p.t2Tick, p.brgTick);
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sq_addr_frame;
    p.frameDone && recogOn && frameMark;
  endsequence

  AST_BCAST_HIT: assert property (sq_addr_frame ##0 ((p.frameData & bcastAddr) == bcastAddr) |=> p.accept)
    else $error("broadcast address not accepted");
  AST_GIVEN_HIT: assert property (sq_addr_frame ##0 (((p.frameData ^ p.ownAddr) & p.addrMask) == 8'h00)
                                  |=> p.accept && !p.reject)
    else $error("given address not accepted");
  AST_ZERO_ANY: assert property (sq_addr_frame ##0 (p.ownAddr == 8'h00) && (p.addrMask == 8'h00) |=> p.accept)
    else $error("cleared address registers refused a frame");
  AST_EXACT_ONLY: assert property (sq_addr_frame ##0 (p.addrMask == 8'hff) && (p.frameData != p.ownAddr)
                                   && (p.frameData != 8'hff) |=> p.reject && !p.accept)
    else $error("full mask accepted a foreign address");
  AST_SHIFT_PASS: assert property (p.frameDone && (p.mode == uafc_pkg::MODE_SHIFT) |=> p.accept)
    else $error("shift mode frame filtered");
  AST_STOP_NEEDED: assert property (p.frameDone && recogOn && (p.mode == uafc_pkg::MODE_UART8) && !p.stopValid
                                    |=> p.reject && !p.accept)
    else $error("mode 1 frame without stop bit accepted");
  AST_TX_BRG: assert property (varRate && p.txGenSel && p.brgTick
                               |=> (p.txSrc == uafc_pkg::SRC_BRG) && p.txTick)
    else $error("transmit clock not from baud generator");
  AST_RX_T2: assert property (varRate && !p.rxGenSel && p.rxT2Sel |=> (p.rxSrc == uafc_pkg::SRC_TIMER2)
                              && (p.rxTick == $past(p.t2Tick)))
    else $error("receive clock not from timer 2");
  // The edge that releases reset still loads the reset codes, so it is left out
  AST_FIXED: assert property (!sys_rst && !varRate |=> (p.txSrc == uafc_pkg::SRC_FIXED)
                              && (p.rxSrc == uafc_pkg::SRC_FIXED) && !p.txTick && !p.rxTick)
    else $error("clock selection active outside modes 1 and 3");

endmodule : uafc_port_filter

// [rtl/uafc_top.sv]
`timescale 1ns/1ps
module uafc_top (
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [11:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp,
  // Receiver frame reports, one lane per port
  input  wire logic [1:0]       frameDone,
  input  wire logic [1:0][7:0]  frameData,
  input  wire logic [1:0]       frameNinth,
  input  wire logic [1:0]       stopValid,
  // Baud ticks from the timers and the per-port generators
  input  wire logic             timer1Tick,
  input  wire logic             timer2Tick,
  input  wire logic [1:0]       brgTick,
  // Results per port, and one interrupt request for both ports
  output logic      [1:0]       receiveFlagSet,
  output logic      [1:0]       addrReject,
  output logic      [1:0]       txBaudTick,
  output logic      [1:0]       rxBaudTick,
  output logic      [1:0][1:0]  txClkSrc,
  output logic      [1:0][1:0]  rxClkSrc,
  output logic                  irq
);

  localparam logic [1:0][9:0] IDX_OWN  = {uafc_pkg::IDX_OWN1,  uafc_pkg::IDX_OWN0};
  localparam logic [1:0][9:0] IDX_MASK = {uafc_pkg::IDX_MASK1, uafc_pkg::IDX_MASK0};
  localparam logic [1:0][9:0] IDX_CTRL = {uafc_pkg::IDX_CTRL1, uafc_pkg::IDX_CTRL0};

  uafc_pkg::uafc_bus_t busState_reg;
  uafc_pkg::uafc_bus_t busState_next;
  logic [9:0]          rdIdx_reg;
  logic [9:0]          wrIdx_reg;
  logic                wrPend_reg;
  logic [31:0]         hrdata_reg;
  logic [1:0][7:0]     ownAddr_reg;
  logic [1:0][7:0]     addrMask_reg;
  logic [1:0][4:0]     ctrl_reg;
  logic [1:0]          t2ctl_reg;
  logic [3:0]          status_reg;
  logic [3:0]          status_next;
  logic [3:0]          ienable_reg;
  logic [31:0]         rdMux;

  // True while the pending write targets the given index
  function automatic logic wr_hit(input logic pend, input logic [9:0] have, input logic [9:0] want);
    return pend && (have == want);
  endfunction : wr_hit

  // Bus address phase decode
  wire addrPhase = hsel && htrans[1] && hready;
  wire rdReq     = addrPhase && !hwrite;
  wire wrReq     = addrPhase && hwrite && (hsize == uafc_pkg::HSIZE_WORD);
  wire rdFinish  = (busState_reg == uafc_pkg::BUS_RDWAIT);
  wire statRead  = rdFinish && (rdIdx_reg == uafc_pkg::IDX_STAT);
  wire [3:0] evSet = {addrReject[1], receiveFlagSet[1], addrReject[0], receiveFlagSet[0]};

  // Read data selection, unmapped words read as zero
  assign rdMux = (rdIdx_reg == uafc_pkg::IDX_OWN0)  ? {24'h000000, ownAddr_reg[0]}  :
                 (rdIdx_reg == uafc_pkg::IDX_OWN1)  ? {24'h000000, ownAddr_reg[1]}  :
                 (rdIdx_reg == uafc_pkg::IDX_MASK0) ? {24'h000000, addrMask_reg[0]} :
                 (rdIdx_reg == uafc_pkg::IDX_MASK1) ? {24'h000000, addrMask_reg[1]} :
                 (rdIdx_reg == uafc_pkg::IDX_CTRL0) ? {27'h0, ctrl_reg[0]}          :
                 (rdIdx_reg == uafc_pkg::IDX_CTRL1) ? {27'h0, ctrl_reg[1]}          :
                 (rdIdx_reg == uafc_pkg::IDX_T2CTL) ? {30'h0, t2ctl_reg}            :
                 (rdIdx_reg == uafc_pkg::IDX_STAT)  ? {28'h0000000, status_reg}     :
                 (rdIdx_reg == uafc_pkg::IDX_IEN)   ? {28'h0000000, ienable_reg}    :
                 32'h00000000;

  // Sticky events; a new event beats the read clear
  assign status_next = (status_reg & ~(statRead ? 4'hf : 4'h0)) | evSet;

  // Bus outputs; reads take one wait state, writes none
  assign hreadyout = !rdFinish;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;
  assign irq       = |(status_reg & ienable_reg);

  // Bus sequencer
  always_comb begin
    busState_next = busState_reg;
    case (busState_reg)
      uafc_pkg::BUS_IDLE: begin
        if (rdReq) begin
          busState_next = uafc_pkg::BUS_RDWAIT;
        end
      end
      uafc_pkg::BUS_RDWAIT: begin
        busState_next = uafc_pkg::BUS_IDLE;
      end
      default: begin
        busState_next = uafc_pkg::BUS_IDLE;
      end
    endcase
  end

  // Address phase capture and read data register
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      busState_reg <= uafc_pkg::BUS_IDLE;
      rdIdx_reg    <= 10'h000;
      wrIdx_reg    <= 10'h000;
      wrPend_reg   <= 1'b0;
      hrdata_reg   <= 32'h00000000;
    end else begin
      busState_reg <= busState_next;
      wrPend_reg   <= wrReq;
      if (addrPhase) begin
        rdIdx_reg <= haddr[11:2];
        wrIdx_reg <= haddr[11:2];
      end
      if (rdFinish) begin
        hrdata_reg <= rdMux;
      end
    end
  end

  // Per-port address and control registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < 2; n++) begin
        ownAddr_reg[n]  <= uafc_pkg::OWN_RST;
        addrMask_reg[n] <= uafc_pkg::MASK_RST;
        ctrl_reg[n]     <= uafc_pkg::CTRL_RST;
      end
    end else begin
      for (int n = 0; n < 2; n++) begin
        if (wr_hit(wrPend_reg, wrIdx_reg, IDX_OWN[n])) begin
          ownAddr_reg[n] <= hwdata[7:0];
        end
        if (wr_hit(wrPend_reg, wrIdx_reg, IDX_MASK[n])) begin
          addrMask_reg[n] <= hwdata[7:0];
        end
        if (wr_hit(wrPend_reg, wrIdx_reg, IDX_CTRL[n])) begin
          ctrl_reg[n] <= hwdata[4:0];
        end
      end
    end
  end

  // Shared timer-2 selects, interrupt status and mask
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      t2ctl_reg   <= uafc_pkg::T2_RST;
      status_reg  <= uafc_pkg::STAT_RST;
      ienable_reg <= uafc_pkg::IEN_RST;
    end else begin
      status_reg <= status_next;
      if (wr_hit(wrPend_reg, wrIdx_reg, uafc_pkg::IDX_T2CTL)) begin
        t2ctl_reg <= hwdata[1:0];
      end
      if (wr_hit(wrPend_reg, wrIdx_reg, uafc_pkg::IDX_IEN)) begin
        ienable_reg <= hwdata[3:0];
      end
    end
  end

  // One filter and clock selector per port
  for (genvar n = 0; n < 2; n++) begin : g_port
    uafc_port_if pif ();

    // Configuration and frame lanes into the port
    assign pif.mode       = uafc_pkg::uafc_mode_t'(ctrl_reg[n][uafc_pkg::CTRL_MODE_LSB +: 2]);
    assign pif.mpEnable   = ctrl_reg[n][uafc_pkg::CTRL_MPE];
    assign pif.rxGenSel   = ctrl_reg[n][uafc_pkg::CTRL_RXGEN];
    assign pif.txGenSel   = ctrl_reg[n][uafc_pkg::CTRL_TXGEN];
    assign pif.rxT2Sel    = t2ctl_reg[uafc_pkg::T2_RXSEL];
    assign pif.txT2Sel    = t2ctl_reg[uafc_pkg::T2_TXSEL];
    assign pif.ownAddr    = ownAddr_reg[n];
    assign pif.addrMask   = addrMask_reg[n];
    assign pif.frameDone  = frameDone[n];
    assign pif.frameData  = frameData[n];
    assign pif.frameNinth = frameNinth[n];
    assign pif.stopValid  = stopValid[n];
    assign pif.t1Tick     = timer1Tick;
    assign pif.t2Tick     = timer2Tick;
    assign pif.brgTick    = brgTick[n];

    uafc_port_filter u_filter (
      .clk     (clk),
      .sys_rst (sys_rst),
      .p       (pif)
    );

    // Results out of the port
    assign receiveFlagSet[n] = pif.accept;
    assign addrReject[n]     = pif.reject;
    assign txBaudTick[n]     = pif.txTick;
    assign rxBaudTick[n]     = pif.rxTick;
    assign txClkSrc[n]       = pif.txSrc;
    assign rxClkSrc[n]       = pif.rxSrc;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  sequence sq_wr_mask0;
    hsel && htrans[1] && hwrite && hready && (hsize == uafc_pkg::HSIZE_WORD)
    && (haddr[11:2] == uafc_pkg::IDX_MASK0);
  endsequence

  sequence sq_wr_own1;
    hsel && htrans[1] && hwrite && hready && (hsize == uafc_pkg::HSIZE_WORD)
    && (haddr[11:2] == uafc_pkg::IDX_OWN1);
  endsequence

  sequence sq_rd_own0;
    hsel && htrans[1] && !hwrite && hready && (haddr[11:2] == uafc_pkg::IDX_OWN0);
  endsequence

  AST_RESET_ZERO: assert property ($past(sys_rst) |-> (ownAddr_reg == 16'h0000) && (addrMask_reg == 16'h0000))
    else $error("address registers not zero after reset");
  AST_MASK0_WRITE: assert property (sq_wr_mask0 ##1 1'b1 |=> addrMask_reg[0] == $past(hwdata[7:0]))
    else $error("mask register of port 0 not written");
  AST_OWN1_WRITE: assert property (sq_wr_own1 ##1 1'b1 |=> (ownAddr_reg[1] == $past(hwdata[7:0]))
                                   && (g_port[1].pif.ownAddr == ownAddr_reg[1]))
    else $error("own address register of port 1 not written");
  AST_OWN0_READ: assert property (sq_rd_own0 |=> !hreadyout ##1 hreadyout
                                  && (hrdata == {24'h000000, $past(ownAddr_reg[0])}))
    else $error("own address of port 0 read back wrong");
  AST_EVENT_STICKY: assert property (receiveFlagSet[0] |=> status_reg[0])
    else $error("accepted frame not recorded");
  AST_IRQ_LEVEL: assert property (status_reg[0] && ienable_reg[0] |-> irq)
    else $error("unmasked status bit without interrupt");

endmodule : uafc_top

// [tb/uafc_master_model.sv]
`timescale 1ns/1ps
module uafc_master_model (
  input  wire logic            clk,
  input  wire logic            sys_rst,
  input  wire logic            req,
  input  wire logic            reqPort,
  input  wire logic [7:0]      reqData,
  input  wire logic            reqNinth,
  input  wire logic            reqStop,
  output logic      [1:0]      frameDone,
  output logic      [1:0][7:0] frameData,
  output logic      [1:0]      frameNinth,
  output logic      [1:0]      stopValid
);
  // One frame per request; idle lanes toggle so a stale byte never looks valid
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      frameDone  <= 2'h0;
      frameData  <= '0;
      frameNinth <= 2'h0;
      stopValid  <= 2'h0;
    end else begin
      for (int i = 0; i < 2; i++) begin
        frameDone[i] <= req && (reqPort == i[0]);
        if (req && (reqPort == i[0])) begin
          frameData[i]  <= reqData;
          frameNinth[i] <= reqNinth;
          stopValid[i]  <= reqStop;
        end else begin
          frameData[i]  <= ~frameData[i];
          frameNinth[i] <= ~frameNinth[i];
          stopValid[i]  <= ~stopValid[i];
        end
      end
    end
  end
endmodule : uafc_master_model

// [tb/uafc_top_tb.sv]
`timescale 1ns/1ps
module uafc_top_tb;
  logic clk, sys_rst, hsel, hwrite, timer1Tick, timer2Tick, req, reqPort, reqNinth, reqStop;
  logic [11:0] haddr;
  logic [1:0] htrans, brgTick, frameDone, frameNinth, stopValid, receiveFlagSet, addrReject;
  logic [1:0] txBaudTick, rxBaudTick, cfgMode [2];
  logic [2:0] hsize;
  logic [31:0] hwdata, hrdata, seed, rd;
  logic [31:0] tickSeed = 32'h5ab13482;
  logic [7:0] reqData, cfgOwn [2], cfgMask [2];
  logic [1:0][7:0] frameData;
  logic [1:0][1:0] txClkSrc, rxClkSrc;
  logic hreadyout, hresp, irq, rstD, cfgMp [2];
  logic txExp, rxExp;
  logic [3:0] tickPrev, expQ [$];
  int failures = 0;
  int testsRun = 0;
  localparam logic [7:0] OWN_TAB [6] = '{8'h00, 8'hf1, 8'hf3, 8'hf2, 8'h56, 8'h56};
  localparam logic [7:0] MASK_TAB [6] = '{8'h00, 8'hfa, 8'hf9, 8'hfd, 8'hff, 8'hfc};
  uafc_top uut (.clk(clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frameDone(frameDone), .frameData(frameData), .frameNinth(frameNinth), .stopValid(stopValid),
    .timer1Tick(timer1Tick), .timer2Tick(timer2Tick), .brgTick(brgTick), .receiveFlagSet(receiveFlagSet),
    .addrReject(addrReject), .txBaudTick(txBaudTick), .rxBaudTick(rxBaudTick), .txClkSrc(txClkSrc),
    .rxClkSrc(rxClkSrc), .irq(irq));
  uafc_master_model master (.clk(clk), .sys_rst(sys_rst), .req(req), .reqPort(reqPort), .reqData(reqData),
    .reqNinth(reqNinth), .reqStop(reqStop), .frameDone(frameDone), .frameData(frameData),
    .frameNinth(frameNinth), .stopValid(stopValid));
  // Random source shared by the tick generator and the main stimulus sequence
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    return s[0] ? ((s >> 1) ^ 32'h80200003) : (s >> 1);
  endfunction : lfsrNext
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic print_verdict();
    if (failures == 0 && testsRun > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : print_verdict
  // Single AHB-Lite transfer; each phase is held until hready is sampled high
  task automatic busXfer(input logic w, input logic [9:0] idx, input logic [2:0] sz, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {idx, 2'b00};
    hwrite <= w;
    hsize <= sz;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    check("hresp", {31'h0, hresp}, 32'h0);
  endtask : busXfer
  task automatic readCheck(input string name, input logic [9:0] idx, input logic [31:0] exp);
    busXfer(1'b0, idx, uafc_pkg::HSIZE_WORD, 32'h0);
    check(name, rd, exp);
  endtask : readCheck
  // Frame request for the partner; expected verdict is noted for the monitor
  task automatic sendFrame(input logic p, input logic [7:0] a, input logic nin, input logic stp);
    logic recog, marker, given, bcast, acc;
    recog = cfgMp[p] && (cfgMode[p] != 2'h0);
    marker = (cfgMode[p] == 2'h1) ? stp : nin;
    given = ((a ^ cfgOwn[p]) & cfgMask[p]) == 8'h00;
    bcast = (a & (cfgOwn[p] | cfgMask[p])) == (cfgOwn[p] | cfgMask[p]);
    acc = !recog || (marker && (given || bcast));
    expQ.push_back({p & !acc, !p & !acc, p & acc, !p & acc});
    req <= 1'b1;
    reqPort <= p;
    reqData <= a;
    reqNinth <= nin;
    reqStop <= stp;
    @(posedge clk);
  endtask : sendFrame
  task automatic setPort(input logic p, input logic [7:0] own, input logic [7:0] msk, input logic [1:0] md,
                         input logic mp);
    cfgOwn[p] = own;
    cfgMask[p] = msk;
    cfgMode[p] = md;
    cfgMp[p] = mp;
    busXfer(1'b1, p ? uafc_pkg::IDX_OWN1 : uafc_pkg::IDX_OWN0, uafc_pkg::HSIZE_WORD, {24'hffffff, own});
    busXfer(1'b1, p ? uafc_pkg::IDX_MASK1 : uafc_pkg::IDX_MASK0, uafc_pkg::HSIZE_WORD, {24'h0, msk});
    busXfer(1'b1, p ? uafc_pkg::IDX_CTRL1 : uafc_pkg::IDX_CTRL0, uafc_pkg::HSIZE_WORD, {29'h0, mp, md});
  endtask : setPort
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Random baud ticks from the timers and generators
  always @(posedge clk) begin
    tickSeed = lfsrNext(tickSeed);
    {brgTick, timer2Tick, timer1Tick} <= tickSeed[3:0];
  end
  // Result monitor: frame verdicts against the oldest note, ticks against the selected source
  always @(posedge clk) begin
    rstD <= sys_rst;
    if (!sys_rst && !rstD) begin
      for (int p = 0; p < 2; p++) begin
        txExp = (txClkSrc[p] == 2'h3) ? 1'b0 : tickPrev[(txClkSrc[p] == 2'h2) ? 2 + p : txClkSrc[p]];
        rxExp = (rxClkSrc[p] == 2'h3) ? 1'b0 : tickPrev[(rxClkSrc[p] == 2'h2) ? 2 + p : rxClkSrc[p]];
        check("txTick", {31'h0, txBaudTick[p]}, {31'h0, txExp});
        check("rxTick", {31'h0, rxBaudTick[p]}, {31'h0, rxExp});
      end
      if ((receiveFlagSet | addrReject) != 2'h0) begin
        if (expQ.size() == 0) check("unexpected frame result", {28'h0, addrReject, receiveFlagSet}, 32'h0);
        else check("frame result", {28'h0, addrReject, receiveFlagSet}, {28'h0, expQ.pop_front()});
      end
    end
    tickPrev <= {brgTick, timer2Tick, timer1Tick};
  end
  initial begin
    #500us;
    failures++;
    print_verdict();
  end
  initial begin
    {hsel, hwrite, req, reqPort, reqData, reqNinth, reqStop, htrans, haddr, hsize, hwdata} = '0;
    cfgMode = '{2'h0, 2'h0};
    cfgMp = '{1'b0, 1'b0};
    seed = 32'h5ab13482;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    readCheck("own0 reset", uafc_pkg::IDX_OWN0, 32'h0);
    readCheck("own1 reset", uafc_pkg::IDX_OWN1, 32'h0);
    readCheck("mask0 reset", uafc_pkg::IDX_MASK0, 32'h0);
    readCheck("mask1 reset", uafc_pkg::IDX_MASK1, 32'h0);
    readCheck("status reset", uafc_pkg::IDX_STAT, 32'h0);
    readCheck("unmapped", 10'h3ff, 32'h0);
    busXfer(1'b1, uafc_pkg::IDX_OWN0, 3'h0, 32'h000000a5);
    readCheck("byte write ignored", uafc_pkg::IDX_OWN0, 32'h0);
    // Byte-wide address and mask registers at their own places
    for (int r = 0; r < 4; r++) begin
      seed = lfsrNext(seed);
      busXfer(1'b1, r[1] ? (r[0] ? uafc_pkg::IDX_MASK1 : uafc_pkg::IDX_MASK0) : (r[0] ? uafc_pkg::IDX_OWN1 :
        uafc_pkg::IDX_OWN0), uafc_pkg::HSIZE_WORD, seed);
      readCheck("address register", r[1] ? (r[0] ? uafc_pkg::IDX_MASK1 : uafc_pkg::IDX_MASK0) : (r[0] ?
        uafc_pkg::IDX_OWN1 : uafc_pkg::IDX_OWN0), {24'h0, seed[7:0]});
    end
    // Recognition across address sets, modes and markers, back to back on alternating ports
    for (int i = 0; i < 14; i++) begin
      setPort(i[0], OWN_TAB[i % 6], MASK_TAB[i % 6], i[2:1] ^ 2'h3, i < 12);
      sendFrame(i[0], 8'hff, 1'b1, 1'b1);
      sendFrame(i[0], 8'hf0, 1'b1, 1'b1);
      sendFrame(i[0], 8'hf3, 1'b1, 1'b1);
      sendFrame(i[0], 8'hf1, 1'b1, 1'b1);
      sendFrame(i[0], 8'hfb, 1'b1, 1'b1);
      sendFrame(i[0], OWN_TAB[i % 6], 1'b1, 1'b1);
      sendFrame(i[0], OWN_TAB[i % 6] | MASK_TAB[i % 6], 1'b0, 1'b1);
      for (int j = 0; j < 8; j++) begin
        seed = lfsrNext(seed);
        sendFrame(i[0] ^ seed[11], seed[7:0], seed[8], seed[9]);
      end
      req <= 1'b0;
      repeat (3) @(posedge clk);
    end
    check("frames answered", expQ.size(), 32'h0);
    // Interrupt: masked, then unmasked, then cleared by the status read
    busXfer(1'b1, uafc_pkg::IDX_IEN, uafc_pkg::HSIZE_WORD, 32'h0);
    busXfer(1'b0, uafc_pkg::IDX_STAT, uafc_pkg::HSIZE_WORD, 32'h0);
    setPort(1'b0, 8'h56, 8'hff, 2'h3, 1'b0);
    sendFrame(1'b0, 8'h12, 1'b0, 1'b0);
    req <= 1'b0;
    repeat (3) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    busXfer(1'b1, uafc_pkg::IDX_IEN, uafc_pkg::HSIZE_WORD, 32'h1);
    @(posedge clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    readCheck("status", uafc_pkg::IDX_STAT, 32'h1);
    readCheck("status cleared", uafc_pkg::IDX_STAT, 32'h0);
    check("irq cleared", {31'h0, irq}, 32'h0);
    // Every clock select combination in every mode for both ports
    for (int k = 0; k < 128; k++) begin
      busXfer(1'b1, k[6] ? uafc_pkg::IDX_CTRL1 : uafc_pkg::IDX_CTRL0, uafc_pkg::HSIZE_WORD, {27'h0, k[3:2], 1'b1,
        k[5:4]});
      busXfer(1'b1, uafc_pkg::IDX_T2CTL, uafc_pkg::HSIZE_WORD, {30'h0, k[1:0]});
      repeat (3) @(posedge clk);
      check("txClkSrc", {30'h0, txClkSrc[k[6]]}, k[4] ? (k[3] ? 32'h2 : {31'h0, k[1]}) : 32'h3);
      check("rxClkSrc", {30'h0, rxClkSrc[k[6]]}, k[4] ? (k[2] ? 32'h2 : {31'h0, k[0]}) : 32'h3);
    end
    // Reset in mid-run clears address and mask registers that hold written values
    sys_rst <= 1'b1;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    readCheck("own1 after reset", uafc_pkg::IDX_OWN1, 32'h0);
    readCheck("mask0 after reset", uafc_pkg::IDX_MASK0, 32'h0);
    print_verdict();
  end
endmodule : uafc_top_tb
